// *** test/cra_access_monitor.sv ***
// Port checker for the core access router.
// Assumes a bind onto cra_core_access; one clock domain.
`timescale 1ns/1ps
`include "cra_defs.vh"
module cra_access_monitor
(
  input wire        mclk,
  input wire        sys_rst,
  input wire        coreReq,
  input wire        dbgReq,
  input wire [2:0]  busPort,
  input wire        busValid,
  input wire [31:0] busAddr,
  input wire        dbgGrant,
  input wire        coreGrant,
  input wire        accessFault,
  input wire        handlerMode,
  input wire        privileged,
  input wire        lockup,
  input wire [1:0]  lockupPri,
  input wire        stacking,
  input wire        vectorFetch
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  chk_code_route: assert property (busValid && busAddr[31:29] == 3'h0 |->
    busPort == `CRA_PORT_INSTR_TIGHT_PORT || busPort == `CRA_PORT_AXI) else $error("code beat on wrong port");
  chk_sram_route: assert property (busValid && busAddr[31:29] == 3'h1 |->
    busPort == `CRA_PORT_DATA_TIGHT_PORT || busPort == `CRA_PORT_AXI) else $error("sram beat on wrong port");
  chk_periph_route: assert property (busValid && busAddr[31:29] == 3'h2 |->
    busPort == `CRA_PORT_PERIPHERAL_AHB_PORT || busPort == `CRA_PORT_AXI) else $error("periph beat on wrong port");
  chk_ext_axi: assert property (busValid && busAddr[31:29] >= 3'h3 && busAddr[31:29] <= 3'h6 |->
    busPort == `CRA_PORT_AXI) else $error("external beat not on axi");
  chk_external_private_periph_port_range: assert property (busValid && busPort == `CRA_PORT_EXTERNAL_PRIVATE_PERIPH_PORT |->
    busAddr >= `CRA_PPB_LO && busAddr <= `CRA_PPB_HI) else $error("external_private_periph_port beat outside private space");
  chk_beat_aligned: assert property (busValid |-> busAddr[1:0] == 2'h0)
    else $error("unaligned beat");
  chk_core_first: assert property (dbgGrant |-> !$past(coreReq) && !coreGrant)
    else $error("debug granted over core");
  chk_fault_nobeat: assert property (accessFault |=> !busValid ##1 !busValid)
    else $error("beat after fault");
  chk_handler_priv: assert property (handlerMode |-> privileged)
    else $error("handler not privileged");
  chk_vector_stack: assert property (vectorFetch |-> stacking)
    else $error("vector fetch outside stacking");
  chk_lockup_pri: assert property (lockup |-> lockupPri == `CRA_PRI_NMI || lockupPri == `CRA_PRI_HARD)
    else $error("lockup priority invalid");
endmodule // cra_access_monitor

// *** test/cra_slave_model.sv ***
// Bus slave model answering each beat after waitCyc+1 cycles.
// Assumes busValid stands until beatDone.
`timescale 1ns/1ps
module cra_slave_model
(
  input  wire       mclk,
  input  wire       sys_rst,
  input  wire       busValid,
  input  wire [1:0] waitCyc,
  input  wire       errMode,
  output reg        beatDone,
  output wire       beatErr
);
  reg [1:0] cnt_q;
  // Error only with done, never floating
  assign beatErr = beatDone & errMode;
  always @(posedge mclk)
  begin
    if (sys_rst || beatDone)
    begin
      beatDone <= 1'h0;
      cnt_q    <= 2'h0;
    end
    else if (busValid)
    begin
      beatDone <= (cnt_q == waitCyc);
      cnt_q    <= cnt_q + 2'h1;
    end
  end
endmodule // cra_slave_model

// *** test/tb_cra_core_access.sv ***
// Testbench for cra_core_access with a bus slave model.
// Assumes the checker is bound below; inputs change at falling edge.
`timescale 1ns/1ps
`include "cra_defs.vh"
module tb_cra_core_access;
  logic mclk, sys_rst, coreReq, coreFetch, coreWrite, coreExclusive, itcmEnable, dtcmEnable, ahbpEnable;
  logic dbgReq, dbgWrite, beatDone, beatErr, irqPending, excReturn, haltReq, errMode, dbgEarly;
  logic [31:0] coreAddr, dbgAddr, vectorData, busAddr;
  logic [1:0] coreSize, waitCyc, lockupPri;
  logic [2:0] busPort;
  logic busValid, dbgGrant, coreGrant, accessFault, neverExecFault, exclusivePass, syncExc, asyncExc;
  logic handlerMode, privileged, debugState, stateBit, invalidStateFault, lockup, stacking, vectorFetch;
  logic coreDevice, inMultiple, multInCond, multBaseLoaded, multEccErr, abandonOp, restartMultiple, continueMultiple;
  logic [9:0] flags;
  logic [34:0] beats[$];
  int err_total = 0, n_checks = 0, cyc = 0, k;
  cra_core_access DUT (.*, .busStrb(), .busWrite());
  cra_slave_model uSlv (.mclk(mclk), .sys_rst(sys_rst), .busValid(busValid), .waitCyc(waitCyc),
    .errMode(errMode), .beatDone(beatDone), .beatErr(beatErr));
  initial
  begin
    mclk = 1'h0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    flags <= flags | {continueMultiple, restartMultiple, abandonOp, dbgGrant, exclusivePass, invalidStateFault,
      asyncExc, syncExc, neverExecFault, accessFault};
    if (busValid && beatDone)
      beats.push_back({busPort, busAddr});
    cyc++;
    // Whole run needs well under this
    if (cyc == 20000)
    begin
      err_total++;
      report_and_stop();
    end
  end
  task report_and_stop;
    if (err_total == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cmp(input logic [34:0] got, input logic [34:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic access(input logic [31:0] a, input logic f, input logic w, input logic [1:0] sz, input logic d);
    @(negedge mclk);
    flags = 10'h000;
    beats.delete();
    {coreAddr, coreFetch, coreWrite, coreSize, coreReq, dbgReq} = {a, f, w, sz, 1'h1, d};
    for (k = 0; k < 20 && coreGrant !== 1'h1 && flags[1:0] == 2'h0; k++) @(negedge mclk);
    dbgEarly = flags[6];
    coreReq = 1'h0;
    for (k = 0; k < 40 && (k < 2 || busValid === 1'h1); k++) @(negedge mclk);
    repeat (3) @(negedge mclk);
  endtask
  task automatic route(input logic [31:0] a, input logic f, input logic e, input logic [2:0] p);
    {itcmEnable, dtcmEnable, ahbpEnable} = {e, e, e};
    access(a, f, 1'h0, `CRA_SZ_WORD, 1'h0);
    cmp(beats.size() == 1 ? beats[0] : 35'h0, {p, a});
  endtask
  task automatic fault(input logic [31:0] a, input logic f, input logic [1:0] sz, input logic [1:0] exp);
    access(a, f, 1'h0, sz, 1'h0);
    cmp({beats.size() == 0, flags[1:0]}, {1'h1, exp});
  endtask
  task automatic exc(input logic [31:0] vec);
    @(negedge mclk);
    flags = 10'h000;
    {vectorData, irqPending} = {vec, 1'h1};
    for (k = 0; k < 60 && handlerMode !== 1'h1; k++) @(negedge mclk);
    irqPending = 1'h0;
    cmp({handlerMode, privileged}, 2'h3);
    for (k = 0; k < 60 && stacking !== 1'h0; k++) @(negedge mclk);
    repeat (4) @(negedge mclk);
    cmp({stateBit, flags[4]}, {vec[0], ~vec[0]});
    excReturn = 1'h1;
    @(negedge mclk);
    excReturn = 1'h0;
    for (k = 0; k < 60 && handlerMode !== 1'h0; k++) @(negedge mclk);
    cmp(handlerMode, 1'h0);
  endtask
  task automatic errs(input logic w);
    errMode = 1'h1;
    access(32'h6000_0010, 1'h0, w, `CRA_SZ_WORD, 1'h0);
    errMode = 1'h0;
    cmp(flags[3:2], w ? 2'h2 : 2'h1);
  endtask
  initial
  begin
    {sys_rst, coreReq, coreFetch, coreWrite, coreExclusive, itcmEnable, dtcmEnable, ahbpEnable} = 8'h80;
    {dbgReq, dbgWrite, irqPending, excReturn, haltReq, errMode, waitCyc, coreSize} = 10'h000;
    {coreAddr, dbgAddr, vectorData} = {32'h0000_0000, 32'hE004_0000, 32'h0000_0201};
    {coreDevice, inMultiple, multInCond, multBaseLoaded, multEccErr} = 5'h00;
    flags = 10'h000;
    repeat (3) @(negedge mclk);
    sys_rst = 1'h0;
    cmp({handlerMode, privileged, stateBit}, 3'h3);
    route(32'h0000_0100, 1'h1, 1'h1, `CRA_PORT_INSTR_TIGHT_PORT);
    route(32'h0000_0200, 1'h0, 1'h0, `CRA_PORT_AXI);
    route(32'h2000_0010, 1'h1, 1'h1, `CRA_PORT_DATA_TIGHT_PORT);
    route(32'h4000_0000, 1'h1, 1'h1, `CRA_PORT_AXI);
    route(32'h4000_0004, 1'h0, 1'h1, `CRA_PORT_PERIPHERAL_AHB_PORT);
    route(32'h6000_0000, 1'h1, 1'h1, `CRA_PORT_AXI);
    route(32'hA000_0008, 1'h0, 1'h1, `CRA_PORT_AXI);
    route(32'hE004_0000, 1'h0, 1'h1, `CRA_PORT_EXTERNAL_PRIVATE_PERIPH_PORT);
    route(32'hE010_0000, 1'h0, 1'h1, `CRA_PORT_PERIPHERAL_AHB_PORT);
    // Slow slave so the second beat waits
    waitCyc = 2'h3;
    access(32'h2000_0002, 1'h0, 1'h0, `CRA_SZ_WORD, 1'h0);
    cmp(beats.size() == 2 ? beats[0] : 35'h0, {`CRA_PORT_DATA_TIGHT_PORT, 32'h2000_0000});
    cmp(beats.size() == 2 ? beats[1] : 35'h0, {`CRA_PORT_DATA_TIGHT_PORT, 32'h2000_0004});
    waitCyc = 2'h0;
    fault(32'h2000_0002, 1'h0, `CRA_SZ_DBL, 2'h1);
    fault(32'hE004_0002, 1'h0, `CRA_SZ_WORD, 2'h1);
    fault(32'hE000_0100, 1'h1, `CRA_SZ_WORD, 2'h2);
    fault(32'hE010_0000, 1'h1, `CRA_SZ_WORD, 2'h2);
    coreExclusive = 1'h1;
    access(32'h2000_0100, 1'h0, 1'h0, `CRA_SZ_WORD, 1'h0);
    access(32'h6000_0040, 1'h0, 1'h1, `CRA_SZ_WORD, 1'h0);
    cmp(flags[5], 1'h1);
    coreExclusive = 1'h0;
    access(32'h0000_0040, 1'h1, 1'h0, `CRA_SZ_WORD, 1'h1);
    for (k = 0; k < 20 && flags[6] !== 1'h1; k++) @(negedge mclk);
    dbgReq = 1'h0;
    cmp({dbgEarly, flags[6]}, 2'h1);
    haltReq = 1'h1;
    for (k = 0; k < 20 && debugState !== 1'h1; k++) @(negedge mclk);
    cmp(debugState, 1'h1);
    haltReq = 1'h0;
    for (k = 0; k < 20 && debugState !== 1'h0; k++) @(negedge mclk);
    cmp(debugState, 1'h0);
    // Idle bus at entry, so the pending op is always abandoned
    inMultiple = 1'h1;
    exc(32'h0000_0201);
    cmp(flags[9:7], 3'h5);
    multInCond = 1'h1;
    exc(32'h0000_0300);
    cmp(flags[9:7], 3'h3);
    {inMultiple, multInCond} = 2'h0;
    errs(1'h0);
    errs(1'h1);
    report_and_stop();
  end
endmodule // tb_cra_core_access
bind cra_core_access cra_access_monitor uMon (.mclk(mclk), .sys_rst(sys_rst), .coreReq(coreReq), .dbgReq(dbgReq),
  .busPort(busPort), .busValid(busValid), .busAddr(busAddr), .dbgGrant(dbgGrant), .coreGrant(coreGrant),
  .accessFault(accessFault), .handlerMode(handlerMode), .privileged(privileged), .lockup(lockup),
  .lockupPri(lockupPri), .stacking(stacking), .vectorFetch(vectorFetch));

// *** verilog/cra_core_access.v ***
// Access router, bus arbiter, exclusive monitor and exception sequencer.
// Assumes bus slaves answer each beat with a done pulse and error flag.
`timescale 1ns/1ps
`include "cra_defs.vh"
module cra_core_access
#(
  parameter STACK_WORDS = 4
)
(
  input  wire        mclk,
  input  wire        sys_rst,
  input  wire        coreReq,
  input  wire        coreFetch,
  input  wire        coreWrite,
  input  wire [31:0] coreAddr,
  input  wire [1:0]  coreSize,
  input  wire        coreExclusive,
  input  wire        coreDevice,
  input  wire        itcmEnable,
  input  wire        dtcmEnable,
  input  wire        ahbpEnable,
  input  wire        dbgReq,
  input  wire [31:0] dbgAddr,
  input  wire        dbgWrite,
  input  wire        beatDone,
  input  wire        beatErr,
  input  wire        irqPending,
  input  wire        excReturn,
  input  wire        haltReq,
  input  wire [31:0] vectorData,
  input  wire        inMultiple,
  input  wire        multInCond,
  input  wire        multBaseLoaded,
  input  wire        multEccErr,
  output reg  [2:0]  busPort,
  output reg         busValid,
  output reg  [31:0] busAddr,
  output reg  [3:0]  busStrb,
  output reg         busWrite,
  output reg         dbgGrant,
  output reg         coreGrant,
  output reg         accessFault,
  output reg         neverExecFault,
  output reg         exclusivePass,
  output reg         syncExc,
  output reg         asyncExc,
  output reg         handlerMode,
  output reg         privileged,
  output reg         debugState,
  output reg         stateBit,
  output reg         invalidStateFault,
  output reg         lockup,
  output reg  [1:0]  lockupPri,
  output reg         stacking,
  output reg         vectorFetch,
  output reg         abandonOp,
  output reg         restartMultiple,
  output reg         continueMultiple
);
  localparam ST_RUN   = 3'h0;
  localparam ST_STACK = 3'h1;
  localparam ST_HAND  = 3'h2;
  localparam ST_UNSTK = 3'h3;
  localparam ST_LOCK  = 3'h4;

  reg  [2:0]  excState_q;
  reg  [3:0]  stackCnt_q;
  reg         inHardFault_q;
  reg         nmiEntry_q;
  reg         exclOpen_q;
  reg         curWrite_q;
  reg         curFetch_q;
  reg         curDevice_q;
  reg  [2:0]  curPort_q;
  reg  [2:0]  routePort;
  reg         routeBad;
  reg         routeXn;
  wire [2:0]  region = coreAddr[31:29];
  wire        inPpb  = (coreAddr >= `CRA_PPB_LO) && (coreAddr <= `CRA_PPB_HI);
  wire        misal  = (coreSize == `CRA_SZ_HALF && coreAddr[0])
                       || (coreSize == `CRA_SZ_WORD && coreAddr[1:0] != 2'b00);
  wire        dblBad = (coreSize == `CRA_SZ_DBL) && (coreAddr[1:0] != 2'b00);
  wire        fetchBad = coreFetch && coreAddr[0];
  wire        splitBusy;
  wire [31:0] splitAddr;
  wire [3:0]  splitStrb;
  wire        splitLast;
  wire        takeCore = coreReq && !splitBusy && excState_q == ST_RUN && !debugState;
  wire        takeDbg  = dbgReq && !coreReq && !splitBusy;

  // Region to port decode
  always @*
  begin
    routePort = `CRA_PORT_AXI;
    routeXn   = 1'b0;
    routeBad  = dblBad || fetchBad;
    case (region)
      `CRA_RGN_CODE:   routePort = itcmEnable ? `CRA_PORT_INSTR_TIGHT_PORT : `CRA_PORT_AXI;
      `CRA_RGN_SRAM:   routePort = dtcmEnable ? `CRA_PORT_DATA_TIGHT_PORT : `CRA_PORT_AXI;
      `CRA_RGN_PERIPH: routePort = (ahbpEnable && !coreFetch) ? `CRA_PORT_PERIPHERAL_AHB_PORT : `CRA_PORT_AXI;
      `CRA_RGN_SYS:
      begin
        routeXn = coreFetch;
        if (inPpb)
        begin
          routePort = `CRA_PORT_EXTERNAL_PRIVATE_PERIPH_PORT;
          routeBad  = routeBad || misal;
        end
        else
          routePort = `CRA_PORT_PERIPHERAL_AHB_PORT;
      end
      default:         routePort = `CRA_PORT_AXI;
    endcase
  end

  cra_splitter u_split
  (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .start    (takeCore && !routeBad && !routeXn),
    .addr     (coreAddr),
    .size     (coreSize),
    .beatDone (beatDone),
    .busy     (splitBusy),
    .beatAddr (splitAddr),
    .beatStrb (splitStrb),
    .last     (splitLast)
  );

  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      busPort <= `CRA_PORT_NONE;
      busValid <= 1'b0;
      busAddr <= 32'h0000_0000;
      busStrb <= 4'h0;
      busWrite <= 1'b0;
      dbgGrant <= 1'b0;
      coreGrant <= 1'b0;
      accessFault <= 1'b0;
      neverExecFault <= 1'b0;
      exclusivePass <= 1'b0;
      syncExc <= 1'b0;
      asyncExc <= 1'b0;
      exclOpen_q <= 1'b0;
      curWrite_q <= 1'b0;
      curFetch_q <= 1'b0;
      curDevice_q <= 1'b0;
      curPort_q <= `CRA_PORT_NONE;
    end
    else
    begin
      coreGrant      <= takeCore;
      dbgGrant       <= takeDbg;
      accessFault    <= takeCore && routeBad;
      neverExecFault <= takeCore && routeXn;
      exclusivePass  <= 1'b0;
      syncExc        <= splitBusy && beatDone && beatErr && !curWrite_q;
      asyncExc       <= splitBusy && beatDone && beatErr && curWrite_q;
      if (takeCore && !routeBad && !routeXn)
      begin
        curWrite_q  <= coreWrite;
        curFetch_q  <= coreFetch;
        curDevice_q <= coreDevice;
        curPort_q   <= routePort;
        // No address held, so any exclusive store matches the open reservation
        if (coreExclusive && !coreWrite)
          exclOpen_q <= 1'b1;
        else if (coreExclusive && coreWrite)
        begin
          exclusivePass <= exclOpen_q;
          exclOpen_q    <= 1'b0;
        end
      end
      if (excState_q == ST_STACK)
        exclOpen_q <= 1'b0;
      busValid <= splitBusy && !(beatDone && splitLast);
      busPort  <= splitBusy ? curPort_q : `CRA_PORT_NONE;
      busAddr  <= splitAddr;
      busStrb  <= splitStrb;
      busWrite <= splitBusy && curWrite_q;
    end
  end

  // Exception sequencer
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      excState_q <= ST_RUN;
      stackCnt_q <= 4'h0;
      inHardFault_q <= 1'b0;
      nmiEntry_q <= 1'b0;
      handlerMode <= 1'b0;
      privileged <= 1'b1;
      debugState <= 1'b0;
      stateBit <= 1'b1;
      invalidStateFault <= 1'b0;
      lockup <= 1'b0;
      lockupPri <= 2'h0;
      stacking <= 1'b0;
      vectorFetch <= 1'b0;
      abandonOp <= 1'b0;
      restartMultiple <= 1'b0;
      continueMultiple <= 1'b0;
    end
    else
    begin
      abandonOp        <= 1'b0;
      restartMultiple  <= 1'b0;
      continueMultiple <= 1'b0;
      invalidStateFault <= 1'b0;
      debugState <= haltReq && excState_q != ST_LOCK;
      case (excState_q)
        ST_RUN, ST_HAND:
        begin
          if (irqPending && !debugState)
          begin
            // Device accesses on the bus finish, and so does an exclusive store while exclusivePass is high
            abandonOp <= !(splitBusy && (curDevice_q || (curWrite_q && exclusivePass)));
            if (inMultiple)
            begin
              if (accessFault || multInCond || multBaseLoaded || multEccErr)
                restartMultiple <= 1'b1;
              else
                continueMultiple <= 1'b1;
            end
            nmiEntry_q <= inHardFault_q;
            excState_q <= ST_STACK;
            stacking <= 1'b1;
            vectorFetch <= 1'b1;
            stackCnt_q <= 4'h0;
          end
          else if (excState_q == ST_HAND && excReturn)
          begin
            excState_q <= ST_UNSTK;
            stackCnt_q <= 4'h0;
          end
        end
        ST_STACK:
        begin
          vectorFetch <= 1'b0;
          if (stackCnt_q == 4'h0)
          begin
            stateBit <= vectorData[0];
            invalidStateFault <= !vectorData[0];
          end
          if (beatErr && nmiEntry_q)
          begin
            excState_q <= ST_LOCK;
            lockup <= 1'b1;
            lockupPri <= `CRA_PRI_NMI;
          end
          else if (stackCnt_q == STACK_WORDS[3:0] - 4'h1)
          begin
            stacking <= 1'b0;
            excState_q <= ST_HAND;
            handlerMode <= 1'b1;
            privileged <= 1'b1;
            inHardFault_q <= !nmiEntry_q && beatErr;
          end
          stackCnt_q <= stackCnt_q + 4'h1;
        end
        ST_UNSTK:
        begin
          if (irqPending)
          begin
            // Tail-chain straight into the next handler
            excState_q <= ST_STACK;
            stackCnt_q <= STACK_WORDS[3:0] - 4'h1;
            vectorFetch <= 1'b1;
          end
          else if (beatErr && nmiEntry_q)
          begin
            excState_q <= ST_LOCK;
            lockup <= 1'b1;
            lockupPri <= `CRA_PRI_HARD;
          end
          else if (stackCnt_q == STACK_WORDS[3:0] - 4'h1)
          begin
            excState_q <= ST_RUN;
            handlerMode <= 1'b0;
            nmiEntry_q <= 1'b0;
          end
          stackCnt_q <= stackCnt_q + 4'h1;
        end
        ST_LOCK:
          excState_q <= ST_LOCK;
        default:
          excState_q <= ST_RUN;
      endcase
    end
  end
endmodule // cra_core_access

// *** verilog/cra_defs.vh ***
// Constants for the core access router and exception sequencer.
// Assumes one 200 MHz clock and a synchronous active-high reset.
`ifndef CRA_DEFS_VH
`define CRA_DEFS_VH
`define CRA_RGN_CODE    3'h0
`define CRA_RGN_SRAM    3'h1
`define CRA_RGN_PERIPH  3'h2
`define CRA_RGN_EXTRAM  3'h3
`define CRA_RGN_EXTRAM2 3'h4
`define CRA_RGN_EXTDEV  3'h5
`define CRA_RGN_EXTDEV2 3'h6
`define CRA_RGN_SYS     3'h7
`define CRA_PPB_LO      32'hE000_0000
`define CRA_PPB_HI      32'hE00F_FFFF
`define CRA_PORT_NONE   3'h0
`define CRA_PORT_INSTR_TIGHT_PORT   3'h1
`define CRA_PORT_DATA_TIGHT_PORT   3'h2
`define CRA_PORT_AXI    3'h3
`define CRA_PORT_PERIPHERAL_AHB_PORT   3'h4
`define CRA_PORT_EXTERNAL_PRIVATE_PERIPH_PORT   3'h5
`define CRA_SZ_BYTE     2'h0
`define CRA_SZ_HALF     2'h1
`define CRA_SZ_WORD     2'h2
`define CRA_SZ_DBL      2'h3
`define CRA_STACK_WORDS 4'h8
`define CRA_PRI_NMI     2'h1
`define CRA_PRI_HARD    2'h2
`endif

// *** verilog/cra_splitter.v ***
// Splits one load/store into aligned word-sized beats.
// Assumes the router has already checked legality of the access.
`timescale 1ns/1ps
`include "cra_defs.vh"
module cra_splitter
(
  input  wire        mclk,
  input  wire        sys_rst,
  input  wire        start,
  input  wire [31:0] addr,
  input  wire [1:0]  size,
  input  wire        beatDone,
  output reg         busy,
  output reg  [31:0] beatAddr,
  output reg  [3:0]  beatStrb,
  output reg         last
);
  reg  [2:0]  beatsLeft;
  reg  [5:0]  laneMask;
  reg  [2:0]  nBeats;
  reg  [7:0]  wideMask;
  always @*
  begin
    case (size)
      `CRA_SZ_BYTE: wideMask = 8'h01 << addr[1:0];
      `CRA_SZ_HALF: wideMask = 8'h03 << addr[1:0];
      `CRA_SZ_WORD: wideMask = 8'h0F << addr[1:0];
      default:      wideMask = 8'hFF;
    endcase
    if (size == `CRA_SZ_DBL)
      nBeats = 3'h2;
    else if (wideMask[7:4] != 4'h0)
      nBeats = 3'h2;
    else
      nBeats = 3'h1;
  end
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      busy      <= 1'b0;
      beatAddr  <= 32'h0000_0000;
      beatStrb  <= 4'h0;
      last      <= 1'b0;
      beatsLeft <= 3'h0;
      laneMask  <= 6'h00;
    end
    else if (start && !busy)
    begin
      busy      <= 1'b1;
      beatAddr  <= {addr[31:2], 2'b00};
      beatStrb  <= (size == `CRA_SZ_DBL) ? 4'hF : wideMask[3:0];
      laneMask  <= {2'b00, wideMask[7:4]};
      beatsLeft <= nBeats;
      last      <= (nBeats == 3'h1);
    end
    else if (busy && beatDone)
    begin
      if (beatsLeft == 3'h1)
      begin
        busy     <= 1'b0;
        beatStrb <= 4'h0;
        last     <= 1'b0;
      end
      else
      begin
        // Second beat is the next aligned word
        beatAddr  <= beatAddr + 32'h0000_0004;
        beatStrb  <= (laneMask[3:0] != 4'h0) ? laneMask[3:0] : 4'hF;
        beatsLeft <= beatsLeft - 3'h1;
        last      <= (beatsLeft == 3'h2);
      end
    end
  end
endmodule // cra_splitter
